/* File: common/eba_regs.vh */
// register offsets, field positions and timing counts of the nv byte access
`ifndef EBA_REGS_VH
`define EBA_REGS_VH

`define EBA_BUS_AW        3
`define EBA_OFF_ADDR_LO   3'h0
`define EBA_OFF_ADDR_HI   3'h1
`define EBA_OFF_DATA      3'h2
`define EBA_OFF_CTRL      3'h3
`define EBA_OFF_IRQ_STAT  3'h4
`define EBA_OFF_IRQ_MASK  3'h5

`define EBA_CTRL_RD_BIT   0
`define EBA_CTRL_ARM_BIT  1
`define EBA_CTRL_PRG_BIT  2
`define EBA_CTRL_MODE_LO  4
`define EBA_CTRL_MODE_HI  5

`define EBA_MODE_ATOMIC   2'h0
`define EBA_MODE_ERASE    2'h1
`define EBA_MODE_WRITE    2'h2

`define EBA_IRQ_DONE_BIT  0
`define EBA_IRQ_REF_BIT   1
`define EBA_IRQ_W         2

`define EBA_NV_BYTES      512
`define EBA_NV_AW         9
`define EBA_ERASED        8'hff

`define EBA_ARM_CYC       3'h4
`define EBA_RD_STALL_CYC  3'h4
`define EBA_PG_STALL_CYC  3'h2

`define EBA_ERASE_CYC     1000
`define EBA_WRITE_CYC     1000
`define EBA_ATOMIC_CYC    2000

`define EBA_DATA_RST      8'h00
`define EBA_ADDR_RST      9'h000
`define EBA_MODE_RST      2'h0

`endif

/* File: rtl/eba_ctrl.v */
// byte access controller for the on-chip 512-byte nonvolatile data store
//
// Behaviour
// - 512 byte-addressed cells, 0x000 to 0x1ff
// - address, data, control on register port
// - read stalls the cpu four cycles
// - programming start stalls the cpu two cycles
// - mode 0 armed strobe runs erase+write
// - program strobe reads busy, self-clears
// - requests while busy are ignored
// - mode 1 armed strobe erases only
// - mode 2 armed strobe writes only
// - read fills data register from address
// - software waits for busy clear first
// - system reset lets programming finish
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.vh"

module eba_ctrl #(
    parameter ERASE_CYC  = `EBA_ERASE_CYC,  // erase-only duration
    parameter WRITE_CYC  = `EBA_WRITE_CYC,  // write-only duration
    parameter ATOMIC_CYC = `EBA_ATOMIC_CYC  // erase+write duration
) (
    input  wire                   I_CLK_SYS, // system clock, 20 MHz
    input  wire                   I_RST_N,   // system reset, async low
    input  wire                   I_POR_N,   // power-on reset, async low
    input  wire [`EBA_BUS_AW-1:0] I_ADDR,    // register address
    input  wire [7:0]             I_WDATA,   // register write data
    input  wire                   I_WR,      // write strobe
    input  wire                   I_RD,      // read strobe
    output reg  [7:0]             O_RDATA,   // read data, next cycle
    output reg                    O_STALL,   // cpu halt request
    output reg                    O_IRQ      // level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // cpu-facing registers
    reg  [`EBA_NV_AW-1:0]  addr_q;
    reg  [7:0]             data_q;
    reg  [1:0]             mode_q;
    reg                    arm_q;
    reg  [2:0]             arm_cnt_q;
    reg  [2:0]             stall_cnt_q;
    reg  [`EBA_IRQ_W-1:0]  stat_q;
    reg  [`EBA_IRQ_W-1:0]  mask_q;

    // programming engine, held only by power-on reset
    reg                    busy_q;
    reg  [15:0]            pcnt_q;
    reg  [1:0]             pmode_q;
    reg  [`EBA_NV_AW-1:0]  paddr_q;
    reg  [7:0]             pdata_q;
    reg                    done_q;

    wire [8*`EBA_NV_BYTES-1:0] cells_w;
    wire [7:0]             rd_byte;

    wire wr_ctrl = I_WR && (I_ADDR == `EBA_OFF_CTRL);
    wire busy    = busy_q;
    wire req_rd  = wr_ctrl && I_WDATA[`EBA_CTRL_RD_BIT];
    wire req_pg  = wr_ctrl && I_WDATA[`EBA_CTRL_PRG_BIT];
    wire req_arm = wr_ctrl && I_WDATA[`EBA_CTRL_ARM_BIT];
    wire do_rd   = req_rd && !busy;
    wire do_pg   = req_pg && arm_q && !busy;
    wire refused = busy && (req_rd || req_pg ||
                   (I_WR && (I_ADDR == `EBA_OFF_ADDR_LO ||
                             I_ADDR == `EBA_OFF_ADDR_HI ||
                             I_ADDR == `EBA_OFF_DATA)));

    assign rd_byte = cells_w[addr_q*8 +: 8];

    ////////////////////////////////////////////////////////////////////////
    // address, data and mode registers
    always @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            addr_q <= `EBA_ADDR_RST;
            data_q <= `EBA_DATA_RST;
            mode_q <= `EBA_MODE_RST;
        end
        else
        begin
            if (I_WR && !busy && I_ADDR == `EBA_OFF_ADDR_LO)
                addr_q[7:0] <= I_WDATA;
            if (I_WR && !busy && I_ADDR == `EBA_OFF_ADDR_HI)
                addr_q[8] <= I_WDATA[0];
            if (do_rd)
                data_q <= rd_byte;
            else if (I_WR && !busy && I_ADDR == `EBA_OFF_DATA)
                data_q <= I_WDATA;
            if (wr_ctrl && !busy)
                mode_q <= I_WDATA[`EBA_CTRL_MODE_HI:`EBA_CTRL_MODE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arming window and cpu stall
    always @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            arm_q       <= 1'b0;
            arm_cnt_q   <= 3'h0;
            stall_cnt_q <= 3'h0;
            O_STALL     <= 1'b0;
        end
        else
        begin
            if (do_pg)
            begin
                arm_q     <= 1'b0;
                arm_cnt_q <= 3'h0;
            end
            else if (req_arm && !req_pg && !busy)
            begin
                arm_q     <= 1'b1;
                arm_cnt_q <= `EBA_ARM_CYC;
            end
            else if (arm_cnt_q != 3'h0)
            begin
                arm_cnt_q <= arm_cnt_q - 3'h1;
                arm_q     <= (arm_cnt_q != 3'h1);
            end
            else
                arm_q <= 1'b0;

            if (do_rd)
            begin
                stall_cnt_q <= `EBA_RD_STALL_CYC - 3'h1;
                O_STALL     <= 1'b1;
            end
            else if (do_pg)
            begin
                stall_cnt_q <= `EBA_PG_STALL_CYC - 3'h1;
                O_STALL     <= 1'b1;
            end
            else if (stall_cnt_q != 3'h0)
            begin
                stall_cnt_q <= stall_cnt_q - 3'h1;
                O_STALL     <= 1'b1;
            end
            else
                O_STALL <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming engine; system reset does not stop a running operation
    always @(posedge I_CLK_SYS or negedge I_POR_N)
    begin
        if (!I_POR_N)
        begin
            busy_q  <= 1'b0;
            pcnt_q  <= 16'h0000;
            pmode_q <= `EBA_MODE_ATOMIC;
            paddr_q <= `EBA_ADDR_RST;
            pdata_q <= `EBA_DATA_RST;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            // capture on the accepted strobe so a system reset right after
            // it cannot lose the operation
            if (do_pg)
            begin
                busy_q  <= 1'b1;
                pmode_q <= I_WDATA[`EBA_CTRL_MODE_HI:`EBA_CTRL_MODE_LO];
                paddr_q <= addr_q;
                pdata_q <= data_q;
                case (I_WDATA[`EBA_CTRL_MODE_HI:`EBA_CTRL_MODE_LO])
                    `EBA_MODE_ERASE: pcnt_q <= ERASE_CYC[15:0];
                    `EBA_MODE_WRITE: pcnt_q <= WRITE_CYC[15:0];
                    default:         pcnt_q <= ATOMIC_CYC[15:0];
                endcase
            end
            else if (busy_q)
            begin
                if (pcnt_q <= 16'h0001)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                    pcnt_q <= pcnt_q - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cell array; the cell is updated as the operation ends
    genvar gi;
    generate
        for (gi = 0; gi < `EBA_NV_BYTES; gi = gi + 1)
        begin : g_cell
            reg [7:0] cell_q;
            always @(posedge I_CLK_SYS)
            begin
                if (busy_q && pcnt_q <= 16'h0001 && paddr_q == gi)
                begin
                    case (pmode_q)
                        `EBA_MODE_ERASE: cell_q <= `EBA_ERASED;
                        `EBA_MODE_WRITE: cell_q <= cell_q & pdata_q;
                        default:         cell_q <= pdata_q;
                    endcase
                end
            end
            assign cells_w[gi*8 +: 8] = cell_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask; a new event wins over a clear
    always @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            stat_q <= {`EBA_IRQ_W{1'b0}};
            mask_q <= {`EBA_IRQ_W{1'b0}};
            O_IRQ  <= 1'b0;
        end
        else
        begin
            stat_q <= (stat_q & ~((I_WR && I_ADDR == `EBA_OFF_IRQ_STAT) ?
                       I_WDATA[`EBA_IRQ_W-1:0] : {`EBA_IRQ_W{1'b0}}))
                      | {refused, done_q};
            if (I_WR && I_ADDR == `EBA_OFF_IRQ_MASK)
                mask_q <= I_WDATA[`EBA_IRQ_W-1:0];
            O_IRQ <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port
    always @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            O_RDATA <= 8'h00;
        else if (I_RD)
        begin
            case (I_ADDR)
                `EBA_OFF_ADDR_LO:  O_RDATA <= addr_q[7:0];
                `EBA_OFF_ADDR_HI:  O_RDATA <= {7'h00, addr_q[8]};
                `EBA_OFF_DATA:     O_RDATA <= data_q;
                `EBA_OFF_CTRL:     O_RDATA <= {2'h0, mode_q, 1'b0,
                                               busy, arm_q, 1'b0};
                `EBA_OFF_IRQ_STAT: O_RDATA <= {6'h00, stat_q};
                `EBA_OFF_IRQ_MASK: O_RDATA <= {6'h00, mask_q};
                default:           O_RDATA <= 8'h00;
            endcase
        end
        else
            O_RDATA <= 8'h00;
    end

endmodule
`default_nettype wire

/* File: tb/eba_ctrl_assertions.sv */
// port-level property checker for the nv byte access controller
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.vh"
module eba_ctrl_assertions (
    input wire logic       I_CLK_SYS, // clock
    input wire logic       I_RST_N,   // reset
    input wire logic [2:0] I_ADDR,    // address
    input wire logic [7:0] I_WDATA,   // write data
    input wire logic       I_WR,      // write strobe
    input wire logic       I_RD,      // read strobe
    input wire logic [7:0] O_RDATA,   // read data
    input wire logic       O_STALL,   // halt
    input wire logic       O_IRQ      // interrupt
);
    logic [2:0] age_q;
    logic       mask_q;
    wire logic  ctl_wr = I_WR && I_ADDR == `EBA_OFF_CTRL;
    // cycles since the last arm write, zero once the window is over
    always @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N)
        begin
            age_q  <= 3'h0;
            mask_q <= 1'b0;
        end
        else
        begin
            if (ctl_wr && I_WDATA[2:1] == 2'h1)
                age_q <= 3'h1;
            else if (age_q != 3'h0)
                age_q <= (age_q == 3'h4) ? 3'h0 : age_q + 3'h1;
            if (I_WR && I_ADDR == `EBA_OFF_IRQ_MASK)
                mask_q <= |I_WDATA[1:0];
        end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    a_stall_cause: assert property (
        $rose(O_STALL) |-> $past(ctl_wr)) else $error("stall without cause");
    a_rd_stall4: assert property (
        $rose(O_STALL) && $past(I_WDATA[2:0]) == 3'h1
        |-> O_STALL[*4] ##1 !O_STALL) else $error("read stall length");
    a_pg_stall2: assert property (
        $rose(O_STALL) && $past(I_WDATA[2:0]) == 3'h4
        |-> O_STALL[*2] ##1 !O_STALL) else $error("program stall length");
    a_arm_window: assert property (
        ctl_wr && I_WDATA[2:0] == 3'h4 && age_q == 3'h0
        |=> !$rose(O_STALL)) else $error("unarmed strobe started");
    a_rdata_idle: assert property (
        !$past(I_RD) |-> O_RDATA == 8'h00) else $error("stray read data");
    a_unmapped_zero: assert property (
        I_RD && I_ADDR > `EBA_OFF_IRQ_MASK |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_read_bit_zero: assert property (
        I_RD && I_ADDR == `EBA_OFF_CTRL |=> !O_RDATA[0])
        else $error("read strobe bit reads one");
    a_irq_masked: assert property (
        (!mask_q)[*2] |-> !O_IRQ) else $error("masked interrupt seen");
endmodule
bind eba_ctrl eba_ctrl_assertions i_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_STALL(O_STALL), .O_IRQ(O_IRQ));
`default_nettype wire

/* File: tb/eba_cpu_model.sv */
// cpu-side register master for the nv byte access controller
`timescale 1ns/1ps
`default_nettype none
module eba_cpu_model (
    input  wire logic       i_clk,   // system clock
    input  wire logic       i_stall, // halt request
    input  wire logic [7:0] i_rdata, // read data
    output var  logic [2:0] o_addr,  // register address
    output var  logic [7:0] o_wdata, // write data
    output var  logic       o_wr,    // write strobe
    output var  logic       o_rd     // read strobe
);
    initial
    begin
        o_addr  = 3'h0;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // a halted cpu issues nothing
    task automatic go;
        #1;
        while (i_stall) @(posedge i_clk) #1;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        go();
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        go();
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the nv byte access controller
`timescale 1ns/1ps
`default_nettype none
`include "eba_regs.vh"
module testbench;
    localparam int PG = 10;
    logic       clk;
    logic       rst_n;
    logic       por_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] v;
    logic       wr;
    logic       rd;
    logic       stall;
    logic       irq;
    int         fails;
    int         total_checks;
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    eba_ctrl #(.ERASE_CYC(6), .WRITE_CYC(6), .ATOMIC_CYC(PG)) i_eba_ctrl (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_STALL(stall), .O_IRQ(irq));
    eba_cpu_model i_eba_cpu_model (
        .i_clk(clk), .i_stall(stall), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cw(input logic [2:0] a, input logic [7:0] d);
        i_eba_cpu_model.wr(a, d);
    endtask
    task automatic cr(input logic [2:0] a, input logic [7:0] e, input string s);
        i_eba_cpu_model.rd(a, v);
        chk(s, e, v);
    endtask
    task automatic prog(input logic [8:0] a, input logic [7:0] d,
                        input logic [1:0] m);
        cw(`EBA_OFF_ADDR_LO, a[7:0]);
        cw(`EBA_OFF_ADDR_HI, {7'h00, a[8]});
        cw(`EBA_OFF_DATA, d);
        cw(`EBA_OFF_CTRL, {2'h0, m, 4'h2});
        cw(`EBA_OFF_CTRL, {2'h0, m, 4'h4});
    endtask
    task automatic drain;
        for (int n = 0; n < 40; n++)
        begin
            i_eba_cpu_model.rd(`EBA_OFF_CTRL, v);
            if (v[2] === 1'b0)
                break;
        end
        chk("busy end", 8'h00, v & 8'h04);
    endtask
    task automatic nvread(input logic [8:0] a, input logic [7:0] e);
        cw(`EBA_OFF_ADDR_LO, a[7:0]);
        cw(`EBA_OFF_ADDR_HI, {7'h00, a[8]});
        cw(`EBA_OFF_CTRL, 8'h01);
        cr(`EBA_OFF_DATA, e, "cell");
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    task automatic conclude;
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial
    begin
        rst_n = 1'b0;
        por_n = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            cr(a[2:0], 8'h00, "reset value");
        prog(9'h1a5, 8'h3c, 2'h0);
        i_eba_cpu_model.rd(`EBA_OFF_CTRL, v);
        chk("busy", 8'h04, v & 8'h34);
        cw(`EBA_OFF_DATA, 8'h77);
        cr(`EBA_OFF_IRQ_STAT, 8'h02, "refused");
        cw(`EBA_OFF_IRQ_STAT, 8'h02);
        drain();
        cr(`EBA_OFF_DATA, 8'h3c, "data kept");
        nvread(9'h1a5, 8'h3c);
        irq_is(1'b0);
        cw(`EBA_OFF_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        cw(`EBA_OFF_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        prog(9'h1a5, 8'h00, 2'h1);
        drain();
        nvread(9'h1a5, 8'hff);
        prog(9'h1a5, 8'h5a, 2'h2);
        drain();
        nvread(9'h1a5, 8'h5a);
        prog(9'h000, 8'h81, 2'h0);
        drain();
        prog(9'h1ff, 8'h42, 2'h0);
        drain();
        nvread(9'h000, 8'h81);
        nvread(9'h1ff, 8'h42);
        cw(`EBA_OFF_DATA, 8'h00);
        cw(`EBA_OFF_CTRL, 8'h02);
        repeat (3) @(posedge clk);
        cw(`EBA_OFF_CTRL, 8'h04);
        cr(`EBA_OFF_CTRL, 8'h00, "late strobe");
        nvread(9'h1a5, 8'h5a);
        prog(9'h0f0, 8'h99, 2'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (PG + 5) @(posedge clk);
        nvread(9'h0f0, 8'h99);
        conclude();
    end
endmodule
`default_nettype wire
